// *** spw_defines.vh ***
// Constants for the 16-bit PWM timer block: register offsets, fields,
// reset values, wave mode codes and fixed TOP values.
// Assumes it is included by bare name from the design files.
//
// Summary of operation
// - Modes 5, 6, 7, 14, 15 count up from zero to TOP, then restart.
// - Fast TOP is 0x00FF/0x01FF/0x03FF, capture top (14) or compare A (15).
// - Fast mode clears the counter on the tick after it matches TOP.
// - Fast non-inverting clears on match, sets at TOP to zero; inverting opposite.
// - Action 2 gives non-inverted PWM, action 3 inverted, in both families.
// - Fast mode sets overflow at TOP, plus compare A or capture flag when TOP source.
// - Fixed TOP modes force compare bits above the resolution to zero on write.
// - Capture top is unbuffered; below count, counter wraps through 0x0000 first.
// - Fast compare writes go to a buffer, loaded at the TOP match.
// - Fast compare zero gives a narrow pulse; compare TOP gives constant level.
// - Fast mode 15 with A action 1 toggles A on each match.
// - Phase correct TOP is fixed (1,2,3), capture (10) or compare A (11); up then down.
// - Phase correct count steps from TOP straight to TOP-1 on the next tick, without holding.
// - Phase correct non-inverting clears on up match, sets on down match.
// - Phase correct sets the overflow flag whenever the counter reaches zero.
// - Phase correct loads compares at TOP and sets compare A or capture flag.
// - Phase correct compare zero holds low, compare TOP holds high (non-inverted).
// - Phase correct mode 11 with A action 1 toggles A on each match.
// - Each channel's compare flag sets when the count equals its compare value.
// - Compare output reaches the pin only when its direction bit selects output.
// - Counter spans 0x0000 to 0xFFFF and wraps at overrun.
// - Action zero leaves the compare output state unchanged on matches.
// - Reset clears the compare output states to zero.
// - Counter is synchronous to the clock and advances only on timer ticks.
`ifndef SPW_DEFINES_VH
`define SPW_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SPW_OFF_CTRL     8'h00
`define SPW_OFF_COUNT    8'h04
`define SPW_OFF_CMPA     8'h08
`define SPW_OFF_CMPB     8'h0C
`define SPW_OFF_CMPC     8'h10
`define SPW_OFF_CAPTOP   8'h14
`define SPW_OFF_FLAGS    8'h18
`define SPW_OFF_DIR      8'h1C
`define SPW_OFF_STATUS   8'h20

// ----------------------------------------------------------------------
// Control fields and flag bits
// ----------------------------------------------------------------------
`define SPW_CTRL_MODE_LSB 0
`define SPW_CTRL_ACTA_LSB 4
`define SPW_CTRL_ACTB_LSB 6
`define SPW_CTRL_ACTC_LSB 8
`define SPW_CTRL_RESET    10'h000
`define SPW_FLAG_OVF      0
`define SPW_FLAG_CAP      1
`define SPW_FLAG_CMPA     2
`define SPW_FLAG_CMPB     3
`define SPW_FLAG_CMPC     4

// ----------------------------------------------------------------------
// Wave modes, actions and counter limits
// ----------------------------------------------------------------------
`define SPW_MODE_PC8      4'h1
`define SPW_MODE_PC9      4'h2
`define SPW_MODE_PC10     4'h3
`define SPW_MODE_PCCAP    4'hA
`define SPW_MODE_PCCMPA   4'hB
`define SPW_MODE_FAST8    4'h5
`define SPW_MODE_FAST9    4'h6
`define SPW_MODE_FAST10   4'h7
`define SPW_MODE_FASTCAP  4'hE
`define SPW_MODE_FASTCMPA 4'hF
`define SPW_ACT_TOGGLE    2'h1
`define SPW_TOP8          16'h00FF
`define SPW_TOP9          16'h01FF
`define SPW_TOP10         16'h03FF
`define SPW_MAX           16'hFFFF
`define SPW_BOTTOM        16'h0000

`endif

// *** spw_cmp_chan.v ***
// One compare channel: buffered compare value, match detect and the
// internal compare output state. Assumes the parent supplies timer ticks.
`timescale 1ns/100ps
`default_nettype none
`include "spw_defines.vh"

module spw_cmp_chan (
	// Clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// Timer sequencing
	input  wire        tick,
	input  wire        run,
	input  wire        fast,
	input  wire        top_hit,
	input  wire        up_eff,
	input  wire        load_now,
	input  wire [15:0] count,
	// Software side
	input  wire        wr_en,
	input  wire [15:0] wr_data,
	input  wire [15:0] wr_mask,
	input  wire [1:0]  action,
	input  wire        allow_toggle,
	// Results
	output wire [15:0] buf_value,
	output wire [15:0] act_value,
	output wire        match,
	output wire        oc_state
);

	reg [15:0] buf_ff;
	reg [15:0] act_ff;
	reg        oc_ff;
	reg        nxt_oc;

	assign buf_value = buf_ff;
	assign act_value = act_ff;
	assign oc_state  = oc_ff;
	assign match     = run & (count == act_ff);

	always @*
	begin
		nxt_oc = oc_ff;
		if (tick)
		begin
			if (match && allow_toggle && action == `SPW_ACT_TOGGLE)
				nxt_oc = ~oc_ff;
			else if (fast && top_hit && action[1])
				nxt_oc = ~action[0];
			else if (match && action[1])
				nxt_oc = (fast | up_eff) ? action[0] : ~action[0];
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			buf_ff <= `SPW_BOTTOM;
			act_ff <= `SPW_BOTTOM;
			oc_ff  <= 1'b0;
		end
		else
		begin
			if (wr_en)
				buf_ff <= wr_data & wr_mask;
			if (load_now || !run)
				act_ff <= buf_ff;
			oc_ff <= nxt_oc;
		end
	end

endmodule
`default_nettype wire

// *** spw_pwm_top.v ***
// Top of the 16-bit PWM timer: APB register file, counter sequencing for
// fast and phase correct PWM, flags and the three compare output pins.
// Assumes timer_tick is a prescaled enable on pclk, one cycle wide.
`timescale 1ns/100ps
`default_nettype none
`include "spw_defines.vh"

module spw_pwm_top (
	// Clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// Timer clock enable
	input  wire        timer_tick,
	// Compare output pins
	output wire [2:0]  pin_out,
	output wire [2:0]  pin_oe_n
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	reg  [9:0]  ctrl_ff;
	reg  [15:0] count_ff;
	reg  [15:0] nxt_count;
	reg         down_ff;
	reg         nxt_down;
	reg  [15:0] captop_ff;
	reg  [4:0]  flags_ff;
	reg  [2:0]  dir_ff;
	reg  [31:0] prdata_ff;
	reg  [31:0] nxt_rdata;
	reg         addr_ok;
	reg  [2:0]  pin_out_ff;
	reg  [2:0]  pin_oe_n_ff;
	reg  [15:0] fixed_mask;
	reg  [15:0] top_val;

	wire [3:0]  wave_mode_sel;
	wire [1:0]  output_action_a_sel;
	wire [1:0]  output_action_b_sel;
	wire [1:0]  output_action_c_sel;
	wire        is_fast;
	wire        is_pc;
	wire        run;
	wire        top_hit;
	wire        at_bottom;
	wire        up_eff;
	wire        load_now;
	wire        tick;
	wire        wr_acc;
	wire        rd_setup;
	wire        top_cap;
	wire        top_cmpa;
	wire [15:0] wdata16;
	wire [15:0] buf_a;
	wire [15:0] buf_b;
	wire [15:0] buf_c;
	wire [15:0] act_a;
	wire [15:0] act_b;
	wire [15:0] act_c;
	wire [2:0]  match;
	wire [2:0]  oc;
	wire [4:0]  flag_set;
	wire [4:0]  flag_clr;

	// ------------------------------------------------------------------
	// Field decode
	// ------------------------------------------------------------------
	assign wave_mode_sel       = ctrl_ff[`SPW_CTRL_MODE_LSB +: 4];
	assign output_action_a_sel = ctrl_ff[`SPW_CTRL_ACTA_LSB +: 2];
	assign output_action_b_sel = ctrl_ff[`SPW_CTRL_ACTB_LSB +: 2];
	assign output_action_c_sel = ctrl_ff[`SPW_CTRL_ACTC_LSB +: 2];

	assign is_fast = (wave_mode_sel == `SPW_MODE_FAST8)  ||
	                 (wave_mode_sel == `SPW_MODE_FAST9)  ||
	                 (wave_mode_sel == `SPW_MODE_FAST10) ||
	                 (wave_mode_sel == `SPW_MODE_FASTCAP) ||
	                 (wave_mode_sel == `SPW_MODE_FASTCMPA);
	assign is_pc   = (wave_mode_sel == `SPW_MODE_PC8)  ||
	                 (wave_mode_sel == `SPW_MODE_PC9)  ||
	                 (wave_mode_sel == `SPW_MODE_PC10) ||
	                 (wave_mode_sel == `SPW_MODE_PCCAP) ||
	                 (wave_mode_sel == `SPW_MODE_PCCMPA);
	assign run      = is_fast | is_pc;
	assign top_cap  = (wave_mode_sel == `SPW_MODE_FASTCAP) ||
	                  (wave_mode_sel == `SPW_MODE_PCCAP);
	assign top_cmpa = (wave_mode_sel == `SPW_MODE_FASTCMPA) ||
	                  (wave_mode_sel == `SPW_MODE_PCCMPA);

	// The tick is already on pclk, so it is used without a synchroniser.
	assign tick = timer_tick & run;

	// ------------------------------------------------------------------
	// TOP selection
	// ------------------------------------------------------------------
	always @*
	begin
		case (wave_mode_sel)
			`SPW_MODE_PC8,
			`SPW_MODE_FAST8:  fixed_mask = `SPW_TOP8;
			`SPW_MODE_PC9,
			`SPW_MODE_FAST9:  fixed_mask = `SPW_TOP9;
			`SPW_MODE_PC10,
			`SPW_MODE_FAST10: fixed_mask = `SPW_TOP10;
			default:          fixed_mask = `SPW_MAX;
		endcase
	end

	always @*
	begin
		if (top_cap)
			top_val = captop_ff;
		else if (top_cmpa)
			top_val = act_a;
		else
			top_val = fixed_mask;
	end

	assign top_hit   = (count_ff == top_val);
	assign at_bottom = (count_ff == `SPW_BOTTOM);
	assign load_now  = tick & top_hit;

	// At BOTTOM a match counts as up-slope and at TOP as down-slope, so a
	// compare of zero or TOP gives a steady level in phase correct mode.
	assign up_eff = at_bottom | (~down_ff & ~top_hit);

	// ------------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------------
	always @*
	begin
		nxt_count = count_ff;
		nxt_down  = down_ff;
		if (wr_acc && paddr == `SPW_OFF_COUNT)
			nxt_count = wdata16;
		else if (tick && is_fast)
		begin
			nxt_down = 1'b0;
			if (top_hit)
				nxt_count = `SPW_BOTTOM;
			else
				nxt_count = count_ff + 16'h0001;
		end
		else if (tick && is_pc)
		begin
			if (!down_ff)
			begin
				if (top_hit)
				begin
					nxt_count = count_ff - 16'h0001;
					nxt_down  = 1'b1;
				end
				else
					nxt_count = count_ff + 16'h0001;
			end
			else if (at_bottom)
			begin
				nxt_count = count_ff + 16'h0001;
				nxt_down  = 1'b0;
			end
			else
				nxt_count = count_ff - 16'h0001;
		end
		if (!run)
			nxt_down = 1'b0;
	end

	// ------------------------------------------------------------------
	// Compare channels
	// ------------------------------------------------------------------
	spw_cmp_chan u_chan_a (
		.pclk         (pclk),
		.presetn      (presetn),
		.tick         (tick),
		.run          (run),
		.fast         (is_fast),
		.top_hit      (top_hit),
		.up_eff       (up_eff),
		.load_now     (load_now),
		.count        (count_ff),
		.wr_en        (wr_acc && paddr == `SPW_OFF_CMPA),
		.wr_data      (wdata16),
		.wr_mask      (fixed_mask),
		.action       (output_action_a_sel),
		.allow_toggle (top_cmpa),
		.buf_value    (buf_a),
		.act_value    (act_a),
		.match        (match[0]),
		.oc_state     (oc[0])
	);

	spw_cmp_chan u_chan_b (
		.pclk         (pclk),
		.presetn      (presetn),
		.tick         (tick),
		.run          (run),
		.fast         (is_fast),
		.top_hit      (top_hit),
		.up_eff       (up_eff),
		.load_now     (load_now),
		.count        (count_ff),
		.wr_en        (wr_acc && paddr == `SPW_OFF_CMPB),
		.wr_data      (wdata16),
		.wr_mask      (fixed_mask),
		.action       (output_action_b_sel),
		.allow_toggle (1'b0),
		.buf_value    (buf_b),
		.act_value    (act_b),
		.match        (match[1]),
		.oc_state     (oc[1])
	);

	spw_cmp_chan u_chan_c (
		.pclk         (pclk),
		.presetn      (presetn),
		.tick         (tick),
		.run          (run),
		.fast         (is_fast),
		.top_hit      (top_hit),
		.up_eff       (up_eff),
		.load_now     (load_now),
		.count        (count_ff),
		.wr_en        (wr_acc && paddr == `SPW_OFF_CMPC),
		.wr_data      (wdata16),
		.wr_mask      (fixed_mask),
		.action       (output_action_c_sel),
		.allow_toggle (1'b0),
		.buf_value    (buf_c),
		.act_value    (act_c),
		.match        (match[2]),
		.oc_state     (oc[2])
	);

	// ------------------------------------------------------------------
	// Flags
	// ------------------------------------------------------------------
	assign flag_set[`SPW_FLAG_OVF]  = tick &
		(is_fast ? top_hit : at_bottom);
	assign flag_set[`SPW_FLAG_CAP]  = load_now & top_cap;
	assign flag_set[`SPW_FLAG_CMPA] = tick &
		(match[0] | (top_hit & top_cmpa));
	assign flag_set[`SPW_FLAG_CMPB] = tick & match[1];
	assign flag_set[`SPW_FLAG_CMPC] = tick & match[2];

	assign flag_clr = (wr_acc && paddr == `SPW_OFF_FLAGS) ?
		pwdata[4:0] : 5'h00;

	// ------------------------------------------------------------------
	// APB access
	// ------------------------------------------------------------------
	assign wdata16  = pwdata[15:0];
	assign wr_acc   = psel & penable & pwrite & addr_ok;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & ~addr_ok;
	assign prdata   = prdata_ff;

	always @*
	begin
		addr_ok   = 1'b1;
		nxt_rdata = 32'h00000000;
		case (paddr)
			`SPW_OFF_CTRL:   nxt_rdata[9:0]  = ctrl_ff;
			`SPW_OFF_COUNT:  nxt_rdata[15:0] = count_ff;
			`SPW_OFF_CMPA:   nxt_rdata[15:0] = buf_a;
			`SPW_OFF_CMPB:   nxt_rdata[15:0] = buf_b;
			`SPW_OFF_CMPC:   nxt_rdata[15:0] = buf_c;
			`SPW_OFF_CAPTOP: nxt_rdata[15:0] = captop_ff;
			`SPW_OFF_FLAGS:  nxt_rdata[4:0]  = flags_ff;
			`SPW_OFF_DIR:    nxt_rdata[2:0]  = dir_ff;
			`SPW_OFF_STATUS: nxt_rdata[3:0]  = {down_ff, oc};
			default:         addr_ok         = 1'b0;
		endcase
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_ff     <= `SPW_CTRL_RESET;
			count_ff    <= `SPW_BOTTOM;
			down_ff     <= 1'b0;
			captop_ff   <= `SPW_BOTTOM;
			flags_ff    <= 5'h00;
			dir_ff      <= 3'h0;
			prdata_ff   <= 32'h00000000;
			pin_out_ff  <= 3'h0;
			pin_oe_n_ff <= 3'h7;
		end
		else
		begin
			count_ff <= nxt_count;
			down_ff  <= nxt_down;
			if (wr_acc && paddr == `SPW_OFF_CTRL)
				ctrl_ff <= pwdata[9:0];
			if (wr_acc && paddr == `SPW_OFF_CAPTOP)
				captop_ff <= wdata16;
			if (wr_acc && paddr == `SPW_OFF_DIR)
				dir_ff <= pwdata[2:0];
			// A set in the same cycle as a clear wins.
			flags_ff <= (flags_ff & ~flag_clr) | flag_set;
			if (rd_setup)
				prdata_ff <= nxt_rdata;
			else if (psel & penable)
				prdata_ff <= prdata_ff;
			else
				prdata_ff <= 32'h00000000;
			pin_out_ff  <= oc & dir_ff;
			pin_oe_n_ff <= ~dir_ff;
		end
	end

	assign pin_out  = pin_out_ff;
	assign pin_oe_n = pin_oe_n_ff;

endmodule
`default_nettype wire

// *** spw_pwm_props.sv ***
// Checker for the PWM timer top: bus answers, pin gating and pin timing.
// Assumes it is bound to spw_pwm_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none

module spw_pwm_props (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB slave
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Timer and pins
	input wire logic        timer_tick,
	input wire logic [2:0]  pin_out,
	input wire logic [2:0]  pin_oe_n
);
	logic apb_wr;
	logic mapped;

	assign apb_wr = psel & penable & pwrite;
	assign mapped = (paddr <= 8'h20) && (paddr[1:0] == 2'h0);

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ready_high: assert property (pready)
		else $error("pready low");
	a_err_mapped: assert property (psel && penable && mapped |-> !pslverr)
		else $error("error on mapped address");
	a_err_unmapped: assert property (psel && penable && paddr > 8'h20 |-> pslverr)
		else $error("no error on unmapped address");
	a_err_idle: assert property (!penable |-> !pslverr)
		else $error("error outside access");
	a_rdata_idle: assert property (psel && penable ##1 !psel |=> prdata == 32'h0)
		else $error("read data not cleared");
	a_pin_gated: assert property ((pin_out & pin_oe_n) == 3'h0)
		else $error("pin driven while input");
	a_reset_pins: assert property ($rose(presetn) |-> pin_out == 3'h0 && pin_oe_n == 3'h7)
		else $error("pins not cleared by reset");
	a_pin_cause: assert property ($changed(pin_out) |-> $past(timer_tick, 2) || $past(apb_wr, 2))
		else $error("pin moved without tick");
	a_oe_cause: assert property ($changed(pin_oe_n) |-> $past(apb_wr, 1) || $past(apb_wr, 2))
		else $error("direction moved without write");

	cover property (apb_wr);
	cover property (psel && penable && pslverr);
	cover property ($changed(pin_out));
endmodule

bind spw_pwm_top spw_pwm_props i_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .timer_tick(timer_tick), .pin_out(pin_out),
	.pin_oe_n(pin_oe_n)
);

`default_nettype wire

// *** spw_load_model.sv ***
// Model of the loads on the three compare pins: a pull-down where the pin
// is released, and a high-cycle count per pin while meas is high.
`timescale 1ns/100ps
`default_nettype none

module spw_load_model (
	// Clock and reset
	input wire logic         pclk,
	input wire logic         presetn,
	// Pins and measurement window
	input wire logic [2:0]   pin_out,
	input wire logic [2:0]   pin_oe_n,
	input wire logic         meas,
	output logic [2:0]       pin_level,
	output logic [47:0]      hi_cnt_ff
);
	logic was_ff;

	// A pin left as input is pulled low by the load.
	assign pin_level = pin_out & ~pin_oe_n;

	always @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			was_ff <= 1'b0;
			hi_cnt_ff <= 48'h0;
		end
		else
		begin
			was_ff <= meas;
			for (int i = 0; i < 3; i++)
				if (meas)
					hi_cnt_ff[16*i +: 16] <= (was_ff ? hi_cnt_ff[16*i +: 16] : 16'h0)
						+ 16'(pin_level[i]);
		end
endmodule

`default_nettype wire

// *** tb_spw_pwm_top.sv ***
// Self-checking bench for the PWM timer: APB tasks, counter and flag
// sequences per mode, and duty measurement through the load model.
`timescale 1ns/100ps
`default_nettype none
`include "spw_defines.vh"

module tb_spw_pwm_top;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic        timer_tick;
	logic        meas;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire  [2:0]  pin_out;
	wire  [2:0]  pin_oe_n;
	wire  [2:0]  pin_level;
	wire  [47:0] hi_cnt;
	int          n_mismatch;
	int          samples_checked;
	int          k;
	logic [31:0] rd;
	logic        err;
	logic [3:0]  m;
	logic [15:0] t;
	logic        fs;
	logic        tg;
	logic        cp;
	logic [3:0]  md [10] = '{4'h5, 4'h6, 4'h7, 4'hE, 4'hF, 4'h1, 4'h2, 4'h3, 4'hA, 4'hB};
	logic [15:0] tp [10] = '{16'h00FF, 16'h01FF, 16'h03FF, 16'h0010, 16'h0020,
		16'h00FF, 16'h01FF, 16'h03FF, 16'h0010, 16'h0020};
	logic [3:0]  wm [8] = '{4'hE, 4'hE, 4'hE, 4'hA, 4'hA, 4'hA, 4'hF, 4'hB};
	logic [15:0] wc [8] = '{16'h2, 16'h0, 16'h7, 16'h3, 16'h0, 16'h7, 16'h2, 16'h3};
	logic [15:0] ea [8] = '{16'h18, 16'h8, 16'h40, 16'h18, 16'h0, 16'h38, 16'h20, 16'h1C};
	logic [15:0] eb [8] = '{16'h28, 16'h38, 16'h0, 16'h20, 16'h38, 16'h0, 16'h28, 16'h20};

	spw_pwm_top i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .timer_tick(timer_tick),
		.pin_out(pin_out), .pin_oe_n(pin_oe_n)
	);
	spw_load_model i_load (
		.pclk(pclk), .presetn(presetn), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.meas(meas), .pin_level(pin_level), .hi_cnt_ff(hi_cnt)
	);

	task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", s, exp, seen);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rchk(input logic [7:0] a, input logic [31:0] e, input string s);
		apb(1'b0, a, 32'h0);
		chk(s, rd, e);
	endtask

	task run(input int n);
		timer_tick <= 1'b1;
		repeat (n)
			@(posedge pclk);
		timer_tick <= 1'b0;
		@(posedge pclk);
	endtask

	task final_report;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		pclk = 1'b0;
		forever
			#50 pclk = ~pclk;
	end

	initial
	begin
		repeat (20000)
			@(posedge pclk);
		n_mismatch++;
		final_report;
	end

	initial
	begin
		{psel, penable, pwrite, timer_tick, meas, presetn} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		n_mismatch = 0;
		samples_checked = 0;
		repeat (4)
			@(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("pins", {pin_oe_n, pin_out}, 6'h38);
		for (k = 0; k < 9; k++)
			rchk(8'(k * 4), 32'h0, "reset value");
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped err", err, 1'b1);
		chk("unmapped data", rd, 32'h0);
		wr(`SPW_OFF_CTRL, 32'h5);
		repeat (5)
			@(posedge pclk);
		rchk(`SPW_OFF_COUNT, 32'h0, "no tick");
		// --------------------------------------------------------------
		// TOP, turnaround and flags in every PWM mode
		// --------------------------------------------------------------
		for (k = 0; k < 10; k++)
		begin
			m = md[k];
			t = tp[k];
			fs = k < 5;
			tg = m == 4'hF || m == 4'hB;
			cp = m == 4'hE || m == 4'hA;
			wr(`SPW_OFF_CTRL, 32'h0);
			wr(`SPW_OFF_CMPA, tg ? {16'h0, t} : 32'h0);
			wr(`SPW_OFF_CAPTOP, {16'h0, t});
			wr(`SPW_OFF_COUNT, 32'h0);
			wr(`SPW_OFF_CTRL, {28'h0, m});
			run(1);
			wr(`SPW_OFF_COUNT, {16'h0, t - 16'h1});
			wr(`SPW_OFF_FLAGS, 32'h1F);
			run(1);
			rchk(`SPW_OFF_COUNT, {16'h0, t}, "at top");
			run(1);
			rchk(`SPW_OFF_COUNT, fs ? 32'h0 : {16'h0, t - 16'h1}, "after top");
			rchk(`SPW_OFF_FLAGS, {29'h0, tg, cp, fs}, "top flags");
			if (!fs)
			begin
				apb(1'b0, `SPW_OFF_STATUS, 32'h0);
				chk("down", rd[3], 1'b1);
				wr(`SPW_OFF_FLAGS, 32'h1F);
				wr(`SPW_OFF_COUNT, 32'h1);
				run(2);
				rchk(`SPW_OFF_FLAGS, tg ? 32'h19 : 32'h1D, "bottom flags");
			end
		end
		for (k = 0; k < 10; k++)
			if (k % 5 < 3)
			begin
				wr(`SPW_OFF_CTRL, {28'h0, md[k]});
				wr(`SPW_OFF_CMPB, 32'hFFFF);
				rchk(`SPW_OFF_CMPB, {16'h0, tp[k]}, "mask");
			end
		wr(`SPW_OFF_CTRL, 32'h0);
		wr(`SPW_OFF_CAPTOP, 32'h7);
		wr(`SPW_OFF_COUNT, 32'hFFFE);
		wr(`SPW_OFF_CTRL, 32'hE);
		wr(`SPW_OFF_FLAGS, 32'h1F);
		run(2);
		rchk(`SPW_OFF_COUNT, 32'h0, "wrap");
		rchk(`SPW_OFF_FLAGS, 32'h0, "no top");
		wr(`SPW_OFF_CTRL, 32'h0);
		wr(`SPW_OFF_CMPA, 32'h20);
		wr(`SPW_OFF_CTRL, 32'hF);
		wr(`SPW_OFF_CMPA, 32'h10);
		rchk(`SPW_OFF_CMPA, 32'h10, "buffer");
		wr(`SPW_OFF_COUNT, 32'hF);
		run(2);
		rchk(`SPW_OFF_COUNT, 32'h11, "old top");
		wr(`SPW_OFF_COUNT, 32'h1F);
		run(2);
		wr(`SPW_OFF_COUNT, 32'hF);
		run(2);
		rchk(`SPW_OFF_COUNT, 32'h0, "new top");
		// --------------------------------------------------------------
		// Waveforms measured at the load
		// --------------------------------------------------------------
		wr(`SPW_OFF_CAPTOP, 32'h7);
		wr(`SPW_OFF_DIR, 32'h7);
		timer_tick <= 1'b1;
		for (k = 0; k < 8; k++)
		begin
			tg = wm[k] == 4'hF || wm[k] == 4'hB;
			fs = wm[k][2];
			wr(`SPW_OFF_CTRL, 32'h0);
			wr(`SPW_OFF_CMPA, tg ? 32'h7 : {16'h0, wc[k]});
			wr(`SPW_OFF_CMPB, {16'h0, wc[k]});
			wr(`SPW_OFF_CMPC, {16'h0, wc[k]});
			wr(`SPW_OFF_CTRL, {24'h0, 2'h3, tg ? 2'h1 : 2'h2, wm[k]});
			repeat (20)
				@(posedge pclk);
			meas <= 1'b1;
			repeat (fs ? 64 : 56)
				@(posedge pclk);
			meas <= 1'b0;
			@(posedge pclk);
			chk("duty a", hi_cnt[15:0], ea[k]);
			chk("duty b", hi_cnt[31:16], eb[k]);
			chk("duty c", hi_cnt[47:32], 16'h0);
		end
		wr(`SPW_OFF_DIR, 32'h5);
		repeat (3)
			@(posedge pclk);
		chk("oe", pin_oe_n, 3'h2);
		chk("released pin", pin_level[1], 1'b0);
		final_report;
	end
endmodule

`default_nettype wire
